// [pdhs_top.v]
// Power-down, long-press and hibernate control of the power manager.
// Assumes a start-up engine that ramps rails and reports completion,
// and a host that reads the system status byte through a read strobe.
//
// Summary of operation
// - Host drops power hold, low-power low: shutdown
// - Long press plus ignored grace: self shutdown
// - Shutdown: reset low first, then rails off
// - Channel off enables its discharge if allowed
// - Full press timeout: interrupt low, flag set
// - Long-press interrupt cannot be masked
// - Status read returns flag and clears it
// - Clearing read releases interrupt, resets both timers
// - Grace expiry without read: go off
// - Read while still pressed restarts the press timer
// - Press timeout selectable 2, 4, 8, 16 s
// - Press select 00..11 maps 2..16 s
// - Grace period selectable 0.1, 0.5, 1, 2 s
// - Grace select 00..11 maps 0.1..2 s
// - Held button never restarts after host shutdown
// - Restart needs button release then new press
// - Hibernate keeps hibernate rails, drops others
// - Low-power falling in hibernate: go off
// - Power hold rising in hibernate: start-up
// - Low-power may fall any time after hold
// - Hibernate rail with sequence include stays on
// - Hibernate rail without include drops at start
// - Kept rail may go forced-PWM at reset release
`timescale 1ns/10ps
`include "pdhs_regs.vh"
module pdhs_top #(
  parameter NCH = 6,
  parameter MS_CYCLES = `PDHS_CLK_HZ / `PDHS_MS_PER_S
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire power_hold_in,
  input wire low_power_request_in,
  input wire start_button_n_in,
  input wire [1:0] press_timeout_sel_in,
  input wire [1:0] press_grace_sel_in,
  input wire [NCH-1:0] discharge_enable_in,
  input wire [NCH-1:0] sequence_include_in,
  input wire [NCH-1:0] hibernate_on_in,
  input wire [NCH-1:0] startup_rails_in,
  input wire [NCH-1:0] run_rails_in,
  input wire startup_done_in,
  input wire startup_abort_in,
  input wire status_rd_in,
  input wire [7:0] status_addr_in,
  output reg [7:0] status_rd_data_out,
  output reg system_reset_out_n,
  output reg interrupt_out_n,
  output reg start_echo_out_n,
  output reg startup_request_out,
  output reg [NCH-1:0] channel_enable_out,
  output reg [NCH-1:0] discharge_on_out,
  output reg forced_pwm_allow_out,
  output reg [4:0] state_out
);
  // ------------------------------------------------------------
  // States, one-hot
  // ------------------------------------------------------------
  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_RUN = 5'h04;
  localparam [4:0] ST_DOWN = 5'h08;
  localparam [4:0] ST_HIB = 5'h10;

  // ------------------------------------------------------------
  // Time selections
  // ------------------------------------------------------------
  function [`PDHS_PRESS_W-1:0] press_ms;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: press_ms = `PDHS_PRESS_MS_0;
        2'h1: press_ms = `PDHS_PRESS_MS_1;
        2'h2: press_ms = `PDHS_PRESS_MS_2;
        default: press_ms = `PDHS_PRESS_MS_3;
      endcase
    end
  endfunction

  function [`PDHS_GRACE_W-1:0] grace_ms;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: grace_ms = `PDHS_GRACE_MS_0;
        2'h1: grace_ms = `PDHS_GRACE_MS_1;
        2'h2: grace_ms = `PDHS_GRACE_MS_2;
        default: grace_ms = `PDHS_GRACE_MS_3;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  wire [2:0] pins_s;
  wire hold_s;
  wire lpr_s;
  wire btn_n_s;

  pdhs_sync #(
    .WIDTH(3),
    .RESET_VAL(`PDHS_PIN_RST)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({start_button_n_in, low_power_request_in, power_hold_in}),
    .sync_out(pins_s)
  );

  assign hold_s = pins_s[0];
  assign lpr_s = pins_s[1];
  assign btn_n_s = pins_s[2];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg hold_prev_q;
  reg lpr_prev_q;
  reg armed_q;
  reg flag_q;
  reg grace_run_q;
  reg [`PDHS_PRESC_W-1:0] presc_q;
  reg [`PDHS_PRESS_W-1:0] press_cnt_q;
  reg [`PDHS_GRACE_W-1:0] grace_cnt_q;
  reg [NCH-1:0] chan_d;
  reg down_to_hib_q;

  wire ms_tick;
  wire hold_rise;
  wire lpr_fall;
  wire rd_status;
  wire press_exp;
  wire grace_exp;
  wire host_down;

  assign ms_tick = (presc_q == MS_CYCLES[`PDHS_PRESC_W-1:0] - 1'b1);
  assign hold_rise = hold_s & ~hold_prev_q;
  assign lpr_fall = ~lpr_s & lpr_prev_q;
  assign rd_status = status_rd_in & (status_addr_in == `PDHS_SYS_STATUS_OFS);
  // Press timer only counts while the flag is clear, so re-arming needs a read
  assign press_exp = ms_tick & ~flag_q & ~btn_n_s &
    (press_cnt_q == press_ms(press_timeout_sel_in) - 1'b1);
  assign grace_exp = ms_tick & grace_run_q &
    (grace_cnt_q == grace_ms(press_grace_sel_in) - 1'b1);
  // Power hold low alone; the low-power level only picks hibernate or off
  assign host_down = ~hold_s;

  // ------------------------------------------------------------
  // Sequencing state machine
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        // A low level left over from before shutdown is not a wake event
        if (hold_rise || (armed_q && !btn_n_s)) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (startup_abort_in) begin
          state_d = ST_OFF;
        end else if (startup_done_in && hold_s) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (host_down || grace_exp) begin
          state_d = ST_DOWN;
        end
      end
      ST_DOWN: begin
        state_d = down_to_hib_q ? ST_HIB : ST_OFF;
      end
      ST_HIB: begin
        if (hold_rise) begin
          state_d = ST_START;
        end else if (lpr_fall) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  // ------------------------------------------------------------
  // Channel enables
  // ------------------------------------------------------------
  always @* begin
    case (state_q)
      ST_START: begin
        // Kept rails bridge into the new sequence only with include set
        chan_d = (channel_enable_out & hibernate_on_in & sequence_include_in) |
          startup_rails_in;
      end
      ST_RUN: chan_d = run_rails_in;
      ST_HIB: begin
        // Rails without include drop on the very edge the new start-up begins
        chan_d = channel_enable_out & hibernate_on_in &
          ((state_d == ST_START) ? sequence_include_in : {NCH{1'b1}});
      end
      ST_DOWN: begin
        chan_d = down_to_hib_q ? (channel_enable_out & hibernate_on_in) :
          {NCH{1'b0}};
      end
      default: chan_d = {NCH{1'b0}};
    endcase
    if (state_d == ST_OFF) begin
      chan_d = {NCH{1'b0}};
    end
  end

  // ------------------------------------------------------------
  // Sequential logic
  // ------------------------------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_OFF;
      hold_prev_q <= 1'b0;
      lpr_prev_q <= 1'b0;
      armed_q <= 1'b0;
      flag_q <= 1'b0;
      grace_run_q <= 1'b0;
      presc_q <= {`PDHS_PRESC_W{1'b0}};
      press_cnt_q <= {`PDHS_PRESS_W{1'b0}};
      grace_cnt_q <= {`PDHS_GRACE_W{1'b0}};
      down_to_hib_q <= 1'b0;
      status_rd_data_out <= `PDHS_SYS_STATUS_RST;
      system_reset_out_n <= 1'b0;
      interrupt_out_n <= 1'b1;
      start_echo_out_n <= 1'b1;
      startup_request_out <= 1'b0;
      channel_enable_out <= {NCH{1'b0}};
      discharge_on_out <= {NCH{1'b0}};
      forced_pwm_allow_out <= 1'b0;
      state_out <= ST_OFF;
    end else begin
      state_q <= state_d;
      state_out <= state_d;
      hold_prev_q <= hold_s;
      lpr_prev_q <= lpr_s;
      start_echo_out_n <= btn_n_s;
      presc_q <= ms_tick ? {`PDHS_PRESC_W{1'b0}} : presc_q + 1'b1;
      startup_request_out <= (state_d == ST_START) && (state_q != ST_START);

      // Wake arming: only a release seen after the shutdown decision arms a button wake
      if (state_q == ST_START || state_d == ST_DOWN) begin
        armed_q <= 1'b0;
      end else if (btn_n_s) begin
        armed_q <= 1'b1;
      end

      // Hibernate or power-off is decided by low-power at the hold drop
      if (state_q == ST_RUN && state_d == ST_DOWN) begin
        down_to_hib_q <= lpr_s & hold_s == 1'b0 & ~grace_exp;
      end

      // Reset asserts on the same edge the shutdown is decided
      if (state_d != ST_RUN) begin
        system_reset_out_n <= 1'b0;
      end else begin
        system_reset_out_n <= 1'b1;
      end
      // Leaving light-load mode waits for reset release and low-power low
      forced_pwm_allow_out <= (state_d == ST_RUN) & ~lpr_s;

      channel_enable_out <= chan_d;
      discharge_on_out <= ~chan_d & discharge_enable_in &
        (channel_enable_out | discharge_on_out);

      // Press timer: continuous low only, cleared on release or read
      if (state_q != ST_RUN || btn_n_s || rd_status) begin
        press_cnt_q <= {`PDHS_PRESS_W{1'b0}};
      end else if (press_exp) begin
        press_cnt_q <= {`PDHS_PRESS_W{1'b0}};
      end else if (ms_tick && !flag_q) begin
        press_cnt_q <= press_cnt_q + 1'b1;
      end

      // Grace timer: starts at press expiry, stops on read
      if (press_exp && state_q == ST_RUN) begin
        grace_run_q <= 1'b1;
        grace_cnt_q <= {`PDHS_GRACE_W{1'b0}};
      end else if (rd_status || state_q != ST_RUN || grace_exp) begin
        grace_run_q <= 1'b0;
        grace_cnt_q <= {`PDHS_GRACE_W{1'b0}};
      end else if (ms_tick && grace_run_q) begin
        grace_cnt_q <= grace_cnt_q + 1'b1;
      end

      // Flag: a new expiry in the clearing cycle wins over the read
      if (press_exp && state_q == ST_RUN) begin
        flag_q <= 1'b1;
        interrupt_out_n <= 1'b0;
      end else if (rd_status || state_q != ST_RUN) begin
        flag_q <= 1'b0;
        interrupt_out_n <= 1'b1;
      end

      if (rd_status) begin
        status_rd_data_out <= `PDHS_SYS_STATUS_RST;
        status_rd_data_out[`PDHS_LONG_PRESS_BIT] <= flag_q;
      end
    end
  end
endmodule

// [pdhs_regs.vh]
// Constants of the power-down and hibernate sequencer.
// Assumes a 10 MHz core clock; included by pdhs_top.v only, not by pdhs_sync.v.
`ifndef PDHS_REGS_VH
`define PDHS_REGS_VH

// ------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------
`define PDHS_CLK_HZ 10000000
`define PDHS_MS_PER_S 1000
`define PDHS_PRESC_W 14
// Pin idle levels after reset: button released, hold and low-power low
`define PDHS_PIN_RST 3'h4

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define PDHS_SYS_STATUS_OFS 8'h04
`define PDHS_SYS_STATUS_RST 8'h00
`define PDHS_LONG_PRESS_BIT 5

// ------------------------------------------------------------
// Press timeout, milliseconds (select 00..11)
// ------------------------------------------------------------
`define PDHS_PRESS_W 15
`define PDHS_PRESS_MS_0 15'h07d0
`define PDHS_PRESS_MS_1 15'h0fa0
`define PDHS_PRESS_MS_2 15'h1f40
`define PDHS_PRESS_MS_3 15'h3e80

// ------------------------------------------------------------
// Grace period, milliseconds (select 00..11)
// ------------------------------------------------------------
`define PDHS_GRACE_W 15
`define PDHS_GRACE_MS_0 15'h0064
`define PDHS_GRACE_MS_1 15'h01f4
`define PDHS_GRACE_MS_2 15'h03e8
`define PDHS_GRACE_MS_3 15'h07d0

`endif

// [pdhs_sync.v]
// Two-flop synchroniser for the pin inputs of the sequencer.
// Assumes asynchronous pins and a single core clock.
`timescale 1ns/10ps
module pdhs_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  // ------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------
  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second one, to keep metastability contained
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [pdhs_chk_props.sv]
// Port checker for the sequencer top.
// Assumes pdhs_top ports; bound below.
`timescale 1ns/10ps
module pdhs_chk #(parameter NCH = 6) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire status_rd_in,
  input wire [7:0] status_addr_in,
  input wire [NCH-1:0] hibernate_on_in,
  input wire [7:0] status_rd_data_out,
  input wire system_reset_out_n,
  input wire interrupt_out_n,
  input wire startup_request_out,
  input wire [NCH-1:0] channel_enable_out,
  input wire [NCH-1:0] discharge_on_out,
  input wire forced_pwm_allow_out,
  input wire [4:0] state_out
);
  // ------
  // Properties
  // ------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_st = status_rd_in && status_addr_in == 8'h04;
  sequence s_down; $rose(state_out == 5'h08); endsequence
  sequence s_settle;
    !system_reset_out_n ##1 (state_out == 5'h01 || state_out == 5'h10);
  endsequence
  a_down_order: assert property (s_down |-> s_settle)
    else $error("shutdown order broken");
  a_run_free: assert property (state_out == 5'h04 |-> system_reset_out_n)
    else $error("reset low in run");
  a_off_dark: assert property (state_out == 5'h01 |-> channel_enable_out == '0)
    else $error("rail on while off");
  a_dis_exclusive: assert property ((discharge_on_out & channel_enable_out) == '0)
    else $error("discharge on live rail");
  a_hib_subset: assert property (state_out == 5'h10 |->
    (channel_enable_out & ~hibernate_on_in) == '0) else $error("extra rail in hibernate");
  a_read_data: assert property (rd_st |=>
    status_rd_data_out == {2'b00, !$past(interrupt_out_n), 5'h00}) else $error("bad status");
  a_read_release: assert property (rd_st && !interrupt_out_n |=> interrupt_out_n[*2])
    else $error("interrupt kept after read");
  a_other_addr: assert property (status_rd_in && status_addr_in != 8'h04 |=>
    $stable(status_rd_data_out)) else $error("unmapped read changed data");
  a_req_pulse: assert property (startup_request_out |=> !startup_request_out)
    else $error("request too long");
  a_forced_pwm_mode_run: assert property (forced_pwm_allow_out |-> state_out == 5'h04)
    else $error("forced_pwm_mode outside run");
endmodule
bind pdhs_top pdhs_chk #(.NCH(NCH)) u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .status_rd_in(status_rd_in), .status_addr_in(status_addr_in),
  .hibernate_on_in(hibernate_on_in), .status_rd_data_out(status_rd_data_out),
  .system_reset_out_n(system_reset_out_n), .interrupt_out_n(interrupt_out_n),
  .startup_request_out(startup_request_out), .channel_enable_out(channel_enable_out),
  .discharge_on_out(discharge_on_out), .forced_pwm_allow_out(forced_pwm_allow_out),
  .state_out(state_out));

// [pdhs_host_model.sv]
// Host model: reads status on demand or in answer to the interrupt.
// Assumes the sequencer clock; strobe lasts one cycle.
`timescale 1ns/10ps
module pdhs_host_model #(parameter DLY = 10) (
  input wire core_clk_in,
  input wire interrupt_out_n,
  input wire auto_ack_in,
  input wire bench_rd_in,
  input wire [7:0] bench_addr_in,
  output reg status_rd_out = 1'b0,
  output reg [7:0] status_addr_out = 8'h00
);
  integer cnt = 0;
  // ------
  // Read sequencing
  // ------
  // Address wanders while the interrupt is low and rests at a5 while idle
  always @(posedge core_clk_in) begin
    cnt <= interrupt_out_n ? 0 : cnt + 1;
    status_rd_out <= bench_rd_in || (auto_ack_in && cnt == DLY);
    status_addr_out <= bench_rd_in ? bench_addr_in : (cnt == DLY ? 8'h04 : cnt[7:0] ^ 8'ha5);
  end
endmodule

// [pdhs_top_tb.sv]
// Bench for the sequencer: host model, reference timings, rail checks.
// Assumes MS_CYCLES shortened to 2 and a prompt start-up engine.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done = checks_done + 1; if ((a) !== (e)) begin \
  fail_count = fail_count + 1; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module pdhs_top_tb;
  localparam MS = 2;
  reg clk = 0, rst_n = 0, hold = 0, lpr = 0, btn = 1, done = 1, ack = 0, brd = 0;
  reg [1:0] psel = 0, gsel = 0;
  reg [5:0] dis = 0, seq = 0, hib = 0, sr = 6'h3f;
  reg [7:0] baddr = 0;
  wire rd, rst_o_n, int_n, req, forced_pwm_mode, echo_n;
  wire [7:0] addr, rdat;
  wire [5:0] en, dch;
  wire [4:0] st;
  integer fail_count = 0, checks_done = 0, seed = 32'h369b6781, i, t;
  integer pms[$] = '{2000, 4000, 8000, 16000}, gms[$] = '{100, 500, 1000, 2000};
  pdhs_top #(.MS_CYCLES(MS)) uut (.core_clk_in(clk), .rst_n_in(rst_n), .power_hold_in(hold),
    .low_power_request_in(lpr), .start_button_n_in(btn), .press_timeout_sel_in(psel),
    .press_grace_sel_in(gsel), .discharge_enable_in(dis), .sequence_include_in(seq),
    .hibernate_on_in(hib), .startup_rails_in(sr), .run_rails_in(6'h3f),
    .startup_done_in(done), .startup_abort_in(1'b0), .status_rd_in(rd),
    .status_addr_in(addr), .status_rd_data_out(rdat), .system_reset_out_n(rst_o_n),
    .interrupt_out_n(int_n), .start_echo_out_n(echo_n), .startup_request_out(req),
    .channel_enable_out(en), .discharge_on_out(dch), .forced_pwm_allow_out(forced_pwm_mode),
    .state_out(st));
  pdhs_host_model host (.core_clk_in(clk), .interrupt_out_n(int_n), .auto_ack_in(ack),
    .bench_rd_in(brd), .bench_addr_in(baddr), .status_rd_out(rd), .status_addr_out(addr));
  // ------
  // Clock, watchdog, helpers
  // ------
  initial forever #50 clk = ~clk;
  initial begin #(100 * 95000); fail_count = fail_count + 1; test_done; end
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wait_st(input [4:0] e, input integer lim);
    t = 0;
    while (st !== e && t < lim) begin @(posedge clk); #1; t = t + 1; end
    `CHK("state", e, st)
  endtask
  task wait_int(input v, input integer lim);
    t = 0;
    while (int_n !== v && t < lim) begin @(posedge clk); #1; t = t + 1; end
    `CHK("int_n", v, int_n)
  endtask
  task rd_reg(input [7:0] a);
    brd <= 1; baddr <= a;
    @(posedge clk); brd <= 0;
    repeat (4) @(posedge clk); #1;
  endtask
  // ------
  // Scenarios
  // ------
  initial begin
    t = $random(seed);
    dis <= t[5:0];
    t = $random(seed);
    seq <= t[5:0];
    t = $random(seed);
    hib <= t[5:0];
    repeat (8) @(posedge clk); #1;
    `CHK("rst_n", 1'b0, rst_o_n)
    rst_n <= 1;
    // Every select code, host silent: timed press then timed grace
    for (i = 0; i < 4; i = i + 1) begin
      psel <= i[1:0];
      gsel <= i[1:0];
      hold <= 1;
      wait_st(5'h04, 40);
      `CHK("forced_pwm_mode", 1'b1, forced_pwm_mode)
      btn <= 0;
      wait_int(1'b0, pms[i] * MS + 20);
      `CHK("press", 1'b1, t >= (pms[i] - 1) * MS && t <= pms[i] * MS + 6)
      rd_reg(8'h10);
      `CHK("unmasked", 1'b0, int_n)
      wait_st(5'h01, gms[i] * MS + 20);
      t = t + 5;
      `CHK("grace", 1'b1, t >= (gms[i] - 1) * MS && t <= gms[i] * MS + 6)
      `CHK("rails", 6'h00, en)
      `CHK("dch", dis, dch)
      hold <= 0; repeat (20) @(posedge clk); #1;
      `CHK("held", 5'h01, st)
      btn <= 1; repeat (5) @(posedge clk); #1; btn <= 0;
      wait_st(5'h02, 20);
      btn <= 1;
    end
    // Host answers: flag read, press still held restarts timers
    psel <= 1; gsel <= 3; ack <= 1; hold <= 1; wait_st(5'h04, 40);
    btn <= 0;
    wait_int(1'b0, 8020); wait_int(1'b1, 20);
    `CHK("flag", 8'h20, rdat)
    wait_int(1'b0, 8020);
    `CHK("again", 1'b1, t > 7900)
    btn <= 1; wait_int(1'b1, 20);
    rd_reg(8'h04);
    `CHK("clear", 8'h00, rdat)
    repeat (50) @(posedge clk); #1;
    `CHK("stay", 5'h04, st)
    `CHK("echo_hi", 1'b1, echo_n)
    ack <= 0; btn <= 0; repeat (100) @(posedge clk); #1;
    hold <= 0; wait_st(5'h01, 10);
    repeat (50) @(posedge clk); #1;
    `CHK("no_restart", 5'h01, st)
    `CHK("echo_lo", 1'b0, echo_n)
    btn <= 1; hold <= 1; wait_st(5'h04, 40);
    lpr <= 1; hold <= 0;
    wait_st(5'h10, 10);
    `CHK("hib", hib, en)
    sr <= 0; done <= 0; hold <= 1;
    wait_st(5'h02, 10);
    `CHK("req", 1'b1, req)
    `CHK("kept", hib & seq, en)
    sr <= 6'h3f; done <= 1; lpr <= 0; wait_st(5'h04, 20);
    // Low-power is still seen high on the first run edge, so no forced-PWM yet
    `CHK("forced_pwm_mode_lp", 1'b0, forced_pwm_mode)
    repeat (3) @(posedge clk);
    #1;
    `CHK("forced_pwm_mode_late", 1'b1, forced_pwm_mode)
    lpr <= 1; hold <= 0; wait_st(5'h10, 10);
    lpr <= 0; wait_st(5'h01, 10);
    test_done;
  end
endmodule
